// File: hdl/tmr_pkg.sv
/*
  Package for the timer modulo and channel control block: register offsets,
  field positions, reset values and types.
  Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
package tmr_pkg;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [4:0] OFS_TSC = 5'h00;
  localparam logic [4:0] OFS_MODH = 5'h04;
  localparam logic [4:0] OFS_MODL = 5'h08;
  localparam logic [4:0] OFS_CSC = 5'h0c;
  localparam logic [4:0] OFS_CVAL = 5'h10;
  localparam logic [4:0] OFS_CNT = 5'h14;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int TSC_OVF = 7;
  localparam int TSC_CPWM = 5;
  localparam int TSC_CLKH = 4;
  localparam int TSC_CLKL = 3;
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELSB = 3;
  localparam int CSC_ELSA = 2;

  // ****************************************************
  // Reset values and counter constants
  // ****************************************************
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FE = 16'hfffe;
  localparam logic [15:0] CNT_FF = 16'hffff;
  localparam logic [7:0] CSC_RST = 8'h00;
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] ELS_OFF = 2'h0;

  typedef enum logic [1:0] {
    CH_CAPTURE = 2'b00,
    CH_COMPARE = 2'b01,
    CH_EPWM = 2'b10,
    CH_CPWM = 2'b11
  } ch_mode_t;

  typedef struct packed {
    logic cpwm;
    logic [1:0] clks;
  } tsc_cfg_t;

  typedef struct packed {
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] els;
  } csc_cfg_t;

endpackage

// File: hdl/tmr_modch.sv
/*
  Timer counter with buffered modulo and one channel status/control register.
  Assumes a single 40 MHz bus clock; the channel pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_modch (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_background_debug_active,
  input wire logic i_ch_pin,
  output logic o_ch_pin,
  output logic o_ch_pin_oe,
  output logic o_ch_irq,
  output logic o_ovf_irq
);

  // ****************************************************
  // Bus slave: one wait cycle per access
  // ****************************************************
  logic ack_r;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wd;
  assign acc = (i_read | i_write) & ~ack_r;
  // A write commits at the edge where waitrequest is seen low
  assign wr = i_write & ack_r;
  assign rd = i_read & acc;
  assign wd = i_writedata[7:0];

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= ~acc;
    end
  end

  // ****************************************************
  // Synchroniser for the channel pin and debug level
  // ****************************************************
  logic [1:0] pin_s_r;
  logic pin_d_r;
  logic [1:0] dbg_s_r;
  logic dbg;
  assign dbg = dbg_s_r[1];

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s_r <= 2'h0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s_r <= {pin_s_r[0], i_ch_pin};
      pin_d_r <= pin_s_r[1];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dbg_s_r <= 2'h0;
    end else begin
      dbg_s_r <= {dbg_s_r[0], i_background_debug_active};
    end
  end

  // ****************************************************
  // Timer status control and counter
  // ****************************************************
  tmr_pkg::tsc_cfg_t tsc_r;
  logic ovf_r;
  logic ovf_armed_r;
  logic [15:0] cnt_r;
  logic [15:0] mod_r;
  logic [15:0] mod_buf_r;
  logic [1:0] seq_r;
  logic tick;
  logic wrap;
  logic wr_tsc;
  logic wr_modh;
  logic wr_modl;
  logic wr_cnt;
  logic mod_hold;
  logic upd_pt;
  logic rd_tsc;
  assign wr_tsc = wr && i_address == tmr_pkg::OFS_TSC;
  assign wr_modh = wr && i_address == tmr_pkg::OFS_MODH;
  assign wr_modl = wr && i_address == tmr_pkg::OFS_MODL;
  assign wr_cnt = wr && i_address == tmr_pkg::OFS_CNT;
  assign rd_tsc = rd && i_address == tmr_pkg::OFS_TSC;
  assign tick = tsc_r.clks != tmr_pkg::CLK_OFF && !dbg;
  assign wrap = tick && mod_r != tmr_pkg::MOD_RST && cnt_r == mod_r;
  assign mod_hold = seq_r != 2'h0;
  // Step old modulo-1 to modulo, or 0xfffe to 0xffff when free running
  assign upd_pt = tick && ((mod_r == tmr_pkg::MOD_RST) ?
    cnt_r == tmr_pkg::CNT_FE : cnt_r == mod_r - 16'h0001);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tsc_r <= '0;
    end else if (wr_tsc) begin
      tsc_r <= {wd[tmr_pkg::TSC_CPWM], wd[tmr_pkg::TSC_CLKH], wd[tmr_pkg::TSC_CLKL]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= tmr_pkg::CNT_ZERO;
    end else if (wr_cnt || wrap) begin
      cnt_r <= tmr_pkg::CNT_ZERO;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Overflow flag with read-then-write-zero clear; new wrap wins and disarms
  logic ovf_evt;
  assign ovf_evt = (wrap || (tick && mod_r == tmr_pkg::MOD_RST && cnt_r == tmr_pkg::CNT_FF))
    && !mod_hold;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovf_r <= 1'b0;
      ovf_armed_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
      ovf_armed_r <= 1'b0;
    end else if (rd_tsc && ovf_r) begin
      ovf_armed_r <= 1'b1;
    end else if (wr_tsc) begin
      if (ovf_armed_r && !wd[tmr_pkg::TSC_OVF]) begin
        ovf_r <= 1'b0;
      end
      ovf_armed_r <= 1'b0;
    end
  end

  // Modulo write sequencing: bit0 high byte seen, bit1 low byte seen
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seq_r <= 2'h0;
    end else if (wr_tsc) begin
      seq_r <= 2'h0;
    end else if (dbg) begin
      seq_r <= seq_r;
    end else if (wr_modh) begin
      seq_r[0] <= 1'b1;
    end else if (wr_modl) begin
      seq_r[1] <= 1'b1;
    end else if (seq_r == 2'h3 && (tsc_r.clks == tmr_pkg::CLK_OFF || upd_pt)) begin
      seq_r <= 2'h0;
    end
  end

  // Modulo write buffer, bypassed in debug
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mod_buf_r <= tmr_pkg::MOD_RST;
    end else if (!dbg && wr_modh) begin
      mod_buf_r[15:8] <= wd;
    end else if (!dbg && wr_modl) begin
      mod_buf_r[7:0] <= wd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mod_r <= tmr_pkg::MOD_RST;
    end else if (dbg && wr_modh) begin
      mod_r[15:8] <= wd;
    end else if (dbg && wr_modl) begin
      mod_r[7:0] <= wd;
    end else if (!dbg && seq_r == 2'h3 && !wr_tsc &&
                 (tsc_r.clks == tmr_pkg::CLK_OFF || upd_pt)) begin
      mod_r <= mod_buf_r;
    end
  end

  // ****************************************************
  // Channel status control and value
  // ****************************************************
  tmr_pkg::csc_cfg_t csc_r;
  logic [15:0] cval_r;
  logic chf_r;
  logic chf_armed_r;
  logic pin_out_r;
  tmr_pkg::ch_mode_t mode;
  logic ch_evt;
  logic cap_evt;
  logic cmp_evt;
  logic rise;
  logic fall;
  logic full_duty;
  logic wr_csc;
  logic rd_csc;
  logic wr_cval;
  assign wr_csc = wr && i_address == tmr_pkg::OFS_CSC;
  assign rd_csc = rd && i_address == tmr_pkg::OFS_CSC;
  assign wr_cval = wr && i_address == tmr_pkg::OFS_CVAL;
  assign rise = pin_s_r[1] & ~pin_d_r;
  assign fall = ~pin_s_r[1] & pin_d_r;

  always_comb begin
    if (tsc_r.cpwm) begin
      mode = tmr_pkg::CH_CPWM;
    end else if (csc_r.msb) begin
      mode = tmr_pkg::CH_EPWM;
    end else if (csc_r.msa) begin
      mode = tmr_pkg::CH_COMPARE;
    end else begin
      mode = tmr_pkg::CH_CAPTURE;
    end
  end

  // 0% duty: value 0; 100% duty: value above modulo
  assign full_duty = cval_r == tmr_pkg::CNT_ZERO ||
    (mod_r != tmr_pkg::MOD_RST && cval_r > mod_r);
  assign cap_evt = mode == tmr_pkg::CH_CAPTURE &&
    ((csc_r.els[0] && rise) || (csc_r.els[1] && fall));
  assign cmp_evt = mode != tmr_pkg::CH_CAPTURE && csc_r.els != tmr_pkg::ELS_OFF &&
    tick && cnt_r == cval_r &&
    !(mode != tmr_pkg::CH_COMPARE && full_duty);
  assign ch_evt = cap_evt || cmp_evt;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      csc_r <= '0;
    end else if (wr_csc) begin
      csc_r <= {wd[tmr_pkg::CSC_IE], wd[tmr_pkg::CSC_MSB], wd[tmr_pkg::CSC_MSA],
                wd[tmr_pkg::CSC_ELSB], wd[tmr_pkg::CSC_ELSA]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cval_r <= tmr_pkg::CNT_ZERO;
    end else if (cap_evt) begin
      cval_r <= cnt_r;
    end else if (wr_cval && mode != tmr_pkg::CH_CAPTURE) begin
      cval_r <= i_writedata[15:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chf_r <= 1'b0;
      chf_armed_r <= 1'b0;
    end else if (ch_evt) begin
      chf_r <= 1'b1;
      chf_armed_r <= 1'b0;
    end else if (rd_csc && chf_r) begin
      chf_armed_r <= 1'b1;
    end else if (wr_csc) begin
      if (chf_armed_r && !wd[tmr_pkg::CSC_FLAG]) begin
        chf_r <= 1'b0;
      end
      chf_armed_r <= 1'b0;
    end
  end

  // Pin output action per mode and edge field
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_out_r <= 1'b0;
    end else if (mode == tmr_pkg::CH_COMPARE && cmp_evt) begin
      case (csc_r.els)
        2'h1: pin_out_r <= ~pin_out_r;
        2'h2: pin_out_r <= 1'b0;
        2'h3: pin_out_r <= 1'b1;
        default: pin_out_r <= pin_out_r;
      endcase
    end else if (mode != tmr_pkg::CH_COMPARE && mode != tmr_pkg::CH_CAPTURE) begin
      // 0% duty keeps the pin at its inactive level
      if (cval_r == tmr_pkg::CNT_ZERO) begin
        pin_out_r <= csc_r.els[0];
      end else if (wrap || cnt_r == tmr_pkg::CNT_ZERO) begin
        pin_out_r <= ~csc_r.els[0];
      end else if (cmp_evt) begin
        pin_out_r <= csc_r.els[0];
      end
    end
  end

  // ****************************************************
  // Pin and request outputs
  // ****************************************************

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ch_pin <= 1'b0;
      o_ch_pin_oe <= 1'b0;
    end else begin
      o_ch_pin <= pin_out_r;
      o_ch_pin_oe <= csc_r.els != tmr_pkg::ELS_OFF && mode != tmr_pkg::CH_CAPTURE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ch_irq <= 1'b0;
    end else begin
      o_ch_irq <= chf_r & csc_r.ie;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ovf_irq <= 1'b0;
    end else begin
      o_ovf_irq <= ovf_r;
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd) begin
      case (i_address)
        tmr_pkg::OFS_TSC: o_readdata <= {24'h0, ovf_r, 1'b0, tsc_r.cpwm, tsc_r.clks, 3'h0};
        tmr_pkg::OFS_MODH: o_readdata <= {24'h0, mod_r[15:8]};
        tmr_pkg::OFS_MODL: o_readdata <= {24'h0, mod_r[7:0]};
        tmr_pkg::OFS_CSC: o_readdata <= {24'h0, chf_r, csc_r, 2'h0};
        tmr_pkg::OFS_CVAL: o_readdata <= {16'h0, cval_r};
        tmr_pkg::OFS_CNT: o_readdata <= {16'h0, cnt_r};
        default: o_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: verif/tmr_pin_model.sv
/*
  Far-side model: an outside source driving the channel pin.
  Assumes the bench asks for pin levels through i_lvl.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_lvl,
  output logic o_pin
);
  // ****************************************************
  // Pin driver
  // ****************************************************
  // Level only moves on request, so it stays stable between edges
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= i_lvl;
    end
  end
endmodule
`default_nettype wire

// File: verif/tmr_modch_chk.sv
/*
  Port checker for tmr_modch.
  Bound to every tmr_modch instance; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_modch_chk (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_ch_pin_oe,
  input wire logic o_ch_irq,
  input wire logic o_ovf_irq
);
  // ****************************************************
  // Port properties
  // ****************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  AST_WAIT_ONE: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low too long");
  AST_WAIT_ANS: assert property ((i_read || i_write) && o_waitrequest |-> ##[1:2] !o_waitrequest)
    else $error("request not answered");
  AST_WAIT_CAUSE: assert property (!o_waitrequest |-> $past(i_read || i_write))
    else $error("answer without request");
  AST_RD_HOLD: assert property (!i_read && !$past(i_read) |=> $stable(o_readdata))
    else $error("read data moved without read");
  AST_RST_CH: assert property ($rose(i_nrst) |-> !o_ch_irq && !o_ch_pin_oe)
    else $error("channel outputs set after reset");
  AST_RST_OVF: assert property ($rose(i_nrst) |-> !o_ovf_irq)
    else $error("overflow set after reset");
  AST_OVF_HOLD: assert property (o_ovf_irq && !i_write && !$past(i_write) |=> o_ovf_irq)
    else $error("overflow dropped without write");
  AST_CH_HOLD: assert property (o_ch_irq && !i_write && !$past(i_write) |=> o_ch_irq)
    else $error("channel request dropped without write");
  AST_OE_CAUSE: assert property ($rose(o_ch_pin_oe) |-> $past(i_write) || $past(i_write, 2))
    else $error("pin enable rose without write");
endmodule
bind tmr_modch tmr_modch_chk i_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_read(i_read),
  .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_ch_pin_oe(o_ch_pin_oe), .o_ch_irq(o_ch_irq), .o_ovf_irq(o_ovf_irq));
`default_nettype wire

// File: verif/testbench.sv
/*
  Self-checking bench for tmr_modch with a pin model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, rd, wr, dbg, lvl, pin, wreq, chp, choe, chirq, ovirq;
  logic [4:0] adr;
  logic [31:0] wd, rdata, q, d;
  logic [31:0] seed = 32'h8423;
  logic [1:0] els;
  logic ie, x;
  int miscompares, tests_run, cyc, t1, t2, m, m2;
  tmr_modch i_tmr_modch (.i_sys_clk(clk), .i_nrst(nrst), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wreq),
    .i_background_debug_active(dbg), .i_ch_pin(pin), .o_ch_pin(chp),
    .o_ch_pin_oe(choe), .o_ch_irq(chirq), .o_ovf_irq(ovirq));
  tmr_pin_model i_tmr_pin_model (.i_sys_clk(clk), .i_nrst(nrst), .i_lvl(lvl), .o_pin(pin));
  // ****************************************************
  // Clock and helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] v);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {16'h0, v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic wait_hi(input bit sel, output int t);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while ((sel ? chirq : ovirq) !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    t = cyc;
    if (n >= 400) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic clr_ovf();
    bus(0, tmr_pkg::OFS_TSC, 0);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {nrst, rd, wr, dbg, lvl, adr, wd} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(0, tmr_pkg::OFS_CSC, 0);
    chk(q, {24'h0, tmr_pkg::CSC_RST});
    bus(0, tmr_pkg::OFS_MODH, 0);
    chk(q, 0);
    bus(0, 5'h18, 0);
    chk(q, 0);
    $display("reset test done");
    m = 32 + int'(rnd() % 64);
    bus(1, tmr_pkg::OFS_CNT, 0);
    bus(1, tmr_pkg::OFS_MODL, 16'(m));
    bus(1, tmr_pkg::OFS_MODH, 0);
    bus(0, tmr_pkg::OFS_MODL, 0);
    chk(q, m);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
    wait_hi(0, t1);
    bus(0, tmr_pkg::OFS_TSC, 0);
    chk(q[7], 1);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
    wait_hi(0, t2);
    chk(t2 - t1, m + 1);
    clr_ovf();
    bus(1, tmr_pkg::OFS_MODH, 0);
    repeat (200) @(posedge clk);
    chk(ovirq, 0);
    m2 = m + 1 + int'(rnd() % 32);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
    bus(1, tmr_pkg::OFS_MODL, 16'(m2));
    repeat (200) @(posedge clk);
    chk(ovirq, 0);
    bus(1, tmr_pkg::OFS_MODH, 0);
    wait_hi(0, t1);
    clr_ovf();
    wait_hi(0, t1);
    clr_ovf();
    wait_hi(0, t2);
    chk(t2 - t1, m2 + 1);
    $display("modulo test done");
    bus(1, tmr_pkg::OFS_TSC, 0);
    bus(0, tmr_pkg::OFS_CNT, 0);
    d = q;
    repeat (20) @(posedge clk);
    bus(0, tmr_pkg::OFS_CNT, 0);
    chk(q, d);
    dbg <= 1'b1;
    d = rnd() & 32'hff;
    repeat (4) @(posedge clk);
    bus(1, tmr_pkg::OFS_MODH, d[15:0]);
    bus(0, tmr_pkg::OFS_MODH, 0);
    chk(q, d);
    dbg <= 1'b0;
    $display("stop and debug test done");
    for (int i = 0; i < 6; i++) begin
      els = 2'(1 + i % 3);
      ie = rnd() & 1;
      lvl <= (i >= 3);
      repeat (4) @(posedge clk);
      bus(1, tmr_pkg::OFS_CSC, {8'h0, 1'b1, ie, 2'b00, els, 2'b00});
      repeat (4) @(posedge clk);
      lvl <= (i < 3);
      repeat (8) @(posedge clk);
      x = (i < 3) ? els[0] : els[1];
      chk(chirq, x & ie);
      bus(0, tmr_pkg::OFS_CSC, 0);
      chk(q[7], x);
      bus(1, tmr_pkg::OFS_CSC, 0);
      bus(0, tmr_pkg::OFS_CSC, 0);
      chk(q[7], 0);
    end
    $display("capture test done");
    bus(1, tmr_pkg::OFS_CSC, 16'h54);
    bus(1, tmr_pkg::OFS_CVAL, 16'(1 + rnd() % 16));
    bus(1, tmr_pkg::OFS_CNT, 0);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
    wait_hi(1, t1);
    chk(choe, 1);
    chk(chp, 1);
    bus(1, tmr_pkg::OFS_TSC, 0);
    bus(1, tmr_pkg::OFS_CVAL, 0);
    bus(0, tmr_pkg::OFS_CSC, 0);
    chk(q[7], 1);
    bus(1, tmr_pkg::OFS_CSC, 16'h68);
    bus(1, tmr_pkg::OFS_CNT, 0);
    bus(1, tmr_pkg::OFS_TSC, 16'h08);
    repeat (300) @(posedge clk);
    bus(0, tmr_pkg::OFS_CSC, 0);
    chk(q[7], 0);
    chk(chp, 0);
    $display("compare test done");
    give_verdict();
  end
endmodule
`default_nettype wire
